//--- wwdt_top.v
// Window watchdog: 16-bit up counter, reload, window check, reset request
//
// Behaviour
// - Watchdog comes out of every reset enabled and counting.
// - Disable and enable instructions stop and restart counting while no reset request stands.
// - Overflow of the enabled counter raises a reset request.
// - Service while enabled and count is below the window boundary raises reset request.
// - The watchdog count is a 16-bit counter.
// - Source is system clock or wake-up clock, divided by 16384 or 256.
// - Every service that is not early, with no request standing, loads the counter with the programmed reload value.
// - Reset defaults give about 0.13 s from the 500 kHz wake-up clock.
`timescale 1ns/10ps
`include "wwdt_regs.vh"

module wwdt_top #(
    parameter DIV_LONG = `WWDT_DIV_LONG,
    parameter DIV_SHORT = `WWDT_DIV_SHORT
) (
    input wire clock,
    input wire rst,
    // Instructions from the processor
    input wire service_instruction,
    input wire watchdog_disable_instruction,
    input wire watchdog_enable_instruction,
    // Wake-up oscillator and settings to hold
    input wire wakeup_clock,
    input wire config_load,
    input wire config_source_wakeup,
    input wire config_divide_short,
    input wire [`WWDT_COUNT_WIDTH-1:0] watchdog_reload_value,
    input wire [`WWDT_COUNT_WIDTH-1:0] window_boundary,
    // Reset request, status and held settings
    output reg reset_request,
    output reg [1:0] reset_cause,
    output reg watchdog_enabled,
    output reg [`WWDT_COUNT_WIDTH-1:0] watchdog_count,
    output reg source_wakeup,
    output reg divide_short,
    output reg [`WWDT_COUNT_WIDTH-1:0] reload_setting,
    output reg [`WWDT_COUNT_WIDTH-1:0] window_setting
);

    localparam [`WWDT_COUNT_WIDTH-1:0] COUNT_ONE = 16'h0001;

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Service taken before the count has reached the window boundary
    function is_early;
        input [`WWDT_COUNT_WIDTH-1:0] count;
        input [`WWDT_COUNT_WIDTH-1:0] boundary;
        begin
            is_early = (count < boundary);
        end
    endfunction

    // Counter value after one prescaled tick
    function [`WWDT_COUNT_WIDTH-1:0] count_step;
        input [`WWDT_COUNT_WIDTH-1:0] count;
        begin
            count_step = count + COUNT_ONE;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Internal signals

    reg wakeup_prev;
    reg wakeup_edge;
    wire source_tick;
    wire prescale_tick;
    wire prescale_clear;
    wire running;
    wire early_service;
    wire wraps;
    wire count_tick;
    wire overflow;
    wire legal_service;

    reg next_enabled;
    reg next_request;
    reg [1:0] next_cause;
    reg [`WWDT_COUNT_WIDTH-1:0] next_count;

    ////////////////////////////////////////////////////////////////////////
    // Held settings, loaded from the configuration ports on strobe

    // Reload and window words
    always @(posedge clock) begin
        if (rst) begin
            reload_setting <= `WWDT_RELOAD_RST;
            window_setting <= `WWDT_WINDOW_RST;
        end else if (config_load) begin
            reload_setting <= watchdog_reload_value;
            window_setting <= window_boundary;
        end
    end

    // Source and divider selection
    always @(posedge clock) begin
        if (rst) begin
            source_wakeup <= `WWDT_SOURCE_RST;
            divide_short <= `WWDT_DIVIDE_SHORT_RST;
        end else if (config_load) begin
            source_wakeup <= config_source_wakeup;
            divide_short <= config_divide_short;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source selection and prescaler

    // Rising edge of the wake-up clock, sampled as an ordinary input;
    // the pin is tracked in reset so a high level gives no false edge
    always @(posedge clock) begin
        if (rst) begin
            wakeup_prev <= wakeup_clock;
            wakeup_edge <= 1'b0;
        end else begin
            wakeup_prev <= wakeup_clock;
            wakeup_edge <= wakeup_clock & ~wakeup_prev;
        end
    end

    // System clock counts every cycle; wake-up clock once per rising edge
    assign source_tick = source_wakeup ? wakeup_edge : 1'b1;

    // Prescaler keeps its partial count while stopped
    assign running = watchdog_enabled && !reset_request;

    // Restart the divide chain on service or a change of settings
    assign prescale_clear = service_instruction || config_load;

    wwdt_prescaler #(
        .DIV_LONG(DIV_LONG),
        .DIV_SHORT(DIV_SHORT),
        .WIDTH(`WWDT_PRESCALE_WIDTH)
    ) u_prescaler (
        .clock(clock),
        .rst(rst),
        .run(running),
        .clear(prescale_clear),
        .source_tick(source_tick),
        .divide_short(divide_short),
        .tick(prescale_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Count, window check and reset request

    assign early_service = service_instruction && watchdog_enabled &&
        is_early(watchdog_count, window_setting);
    assign wraps = (watchdog_count == `WWDT_COUNT_MAX);

    // A service restarts the chain, so a tick in its cycle is dropped
    assign count_tick = running && prescale_tick && !service_instruction;
    assign overflow = count_tick && wraps;
    assign legal_service = service_instruction && !early_service;

    // Enable wins when both instructions arrive together
    always @* begin
        next_enabled = watchdog_enabled;
        if (watchdog_enable_instruction) begin
            next_enabled = 1'b1;
        end else if (watchdog_disable_instruction) begin
            next_enabled = 1'b0;
        end
    end

    // Request is a sticky level that only rst clears
    always @* begin
        next_request = reset_request;
        if (!reset_request) begin
            if (early_service || overflow) begin
                next_request = 1'b1;
            end
        end
    end

    // Cause is fixed by the request that came first
    always @* begin
        next_cause = reset_cause;
        if (!reset_request) begin
            if (early_service) begin
                next_cause = `WWDT_CAUSE_EARLY;
            end else if (overflow) begin
                next_cause = `WWDT_CAUSE_OVERFLOW;
            end
        end
    end

    // Count freezes while a request stands; early service keeps it
    always @* begin
        next_count = watchdog_count;
        if (!reset_request) begin
            if (legal_service) begin
                next_count = reload_setting;
            end else if (count_tick) begin
                next_count = count_step(watchdog_count);
            end
        end
    end

    // Enabled again by every reset, with no software action
    always @(posedge clock) begin
        if (rst) begin
            watchdog_enabled <= 1'b1;
        end else begin
            watchdog_enabled <= next_enabled;
        end
    end

    // Request stays high until the system reset clears it
    always @(posedge clock) begin
        if (rst) begin
            watchdog_count <= `WWDT_RELOAD_RST;
            reset_request <= 1'b0;
            reset_cause <= `WWDT_CAUSE_NONE;
        end else begin
            watchdog_count <= next_count;
            reset_request <= next_request;
            reset_cause <= next_cause;
        end
    end

endmodule

//--- wwdt_regs.vh
// Constants for the window watchdog: defaults, dividers and cause codes
`ifndef WWDT_REGS_VH
`define WWDT_REGS_VH

// Counter width and the count at which it wraps
`define WWDT_COUNT_WIDTH 16
`define WWDT_COUNT_MAX 16'hFFFF
`define WWDT_COUNT_ZERO 16'h0000

// Reset defaults of the held settings
`define WWDT_RELOAD_RST 16'hFF00
`define WWDT_WINDOW_RST 16'h0000
`define WWDT_SOURCE_RST 1'h1
`define WWDT_DIVIDE_SHORT_RST 1'h1

// Prescaler divide ratios
`define WWDT_DIV_LONG 16384
`define WWDT_DIV_SHORT 256
`define WWDT_PRESCALE_WIDTH 14

// Default interval: 256 ticks of 256 wake-up clocks at 500 kHz
`define WWDT_WAKEUP_FREQ_KHZ 500
`define WWDT_DEFAULT_INTERVAL_US 131072

// Cause of the last reset request
`define WWDT_CAUSE_NONE 2'h0
`define WWDT_CAUSE_OVERFLOW 2'h1
`define WWDT_CAUSE_EARLY 2'h2

`endif

//--- wwdt_prescaler.v
// Prescaler dividing the selected source by the long or short ratio
`timescale 1ns/10ps
`include "wwdt_regs.vh"

module wwdt_prescaler #(
    parameter DIV_LONG = `WWDT_DIV_LONG,
    parameter DIV_SHORT = `WWDT_DIV_SHORT,
    parameter WIDTH = `WWDT_PRESCALE_WIDTH
) (
    input wire clock,
    input wire rst,
    input wire run,
    input wire clear,
    input wire source_tick,
    input wire divide_short,
    output reg tick
);

    // Last count of each ratio, cut to the counter width on purpose
    localparam integer LONG_LAST = DIV_LONG - 1;
    localparam integer SHORT_LAST = DIV_SHORT - 1;
    localparam [WIDTH-1:0] LIMIT_LONG = LONG_LAST[WIDTH-1:0];
    localparam [WIDTH-1:0] LIMIT_SHORT = SHORT_LAST[WIDTH-1:0];
    localparam [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

    reg [WIDTH-1:0] count;
    wire [WIDTH-1:0] limit;

    assign limit = divide_short ? LIMIT_SHORT : LIMIT_LONG;

    always @(posedge clock) begin
        if (rst || clear) begin
            count <= {WIDTH{1'b0}};
            tick <= 1'b0;
        end else if (run && source_tick) begin
            if (count >= limit) begin
                count <= {WIDTH{1'b0}};
                tick <= 1'b1;
            end else begin
                count <= count + ONE;
                tick <= 1'b0;
            end
        end else begin
            tick <= 1'b0;
        end
    end

endmodule

//--- wwdt_wakeup_osc.sv
// Wake-up oscillator model, 500 kHz
`timescale 1ns/10ps
module wwdt_wakeup_osc #(
    parameter HALF_NS = 1000
) (
    output logic wakeup_clock
);
    initial begin
        wakeup_clock = 1'b0;
        #30;
        forever #HALF_NS wakeup_clock = ~wakeup_clock;
    end
endmodule

//--- wwdt_checker_properties.sv
// Port checker for the window watchdog
`timescale 1ns/10ps
module wwdt_checker (
    input wire clock,
    input wire rst,
    input wire service_instruction,
    input wire watchdog_disable_instruction,
    input wire watchdog_enable_instruction,
    input wire reset_request,
    input wire [1:0] reset_cause,
    input wire watchdog_enabled,
    input wire [15:0] watchdog_count,
    input wire [15:0] reload_setting,
    input wire [15:0] window_setting
);
    default clocking @(posedge clock); endclocking
    default disable iff rst;
    ////////////////////////////////////////////////////////////////////
    reset_state_a: assert property ($past(rst) |-> watchdog_enabled
        && !reset_request && watchdog_count == 16'hFF00)
        else $error("bad reset state");
    disable_stop_a: assert property (watchdog_disable_instruction &&
        !watchdog_enable_instruction |=> !watchdog_enabled)
        else $error("disable lost");
    enable_start_a: assert property (
        watchdog_enable_instruction |=> watchdog_enabled)
        else $error("enable lost");
    count_up_a: assert property (
        watchdog_count != $past(watchdog_count) && !$past(rst) &&
        !$past(service_instruction) |-> watchdog_count ==
        $past(watchdog_count) + 16'h1) else $error("bad step");
    overflow_req_a: assert property (
        $past(watchdog_count) == 16'hFFFF && watchdog_count == 16'h0000 &&
        !$past(rst) && !$past(service_instruction) |-> reset_request &&
        reset_cause == 2'h1) else $error("overflow missed");
    early_service_a: assert property (
        service_instruction && watchdog_enabled && !reset_request &&
        watchdog_count < window_setting |=> reset_request &&
        reset_cause == 2'h2 && $stable(watchdog_count))
        else $error("early missed");
    service_reload_a: assert property (
        service_instruction && !reset_request && (!watchdog_enabled ||
        watchdog_count >= window_setting) |=> watchdog_count ==
        $past(reload_setting)) else $error("no reload");
    request_sticky_a: assert property (
        reset_request |=> reset_request && $stable(watchdog_count))
        else $error("request dropped");
endmodule

//--- tb_top.sv
// Testbench driving the window watchdog as servicing software
`timescale 1ns/10ps
module tb_top;
    localparam int TICK = 4 * 20;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic [3:0] st = 4'h0;
    logic src = 1'h1;
    logic shrt = 1'h1;
    logic [15:0] rel = 16'hFF00;
    logic [15:0] win = 16'h0000;
    wire wk;
    wire req;
    wire [1:0] cause;
    wire en;
    wire [15:0] cnt;
    wire src_q;
    wire div_q;
    wire [15:0] rel_q;
    wire [15:0] win_q;
    int bad_count = 0;
    int n_compared = 0;
    int n;
    wwdt_wakeup_osc u_osc (.wakeup_clock(wk));
    wwdt_top #(.DIV_LONG(16), .DIV_SHORT(4)) u_dut (.clock(clock),
        .rst(rst), .service_instruction(st[0]),
        .watchdog_disable_instruction(st[1]),
        .watchdog_enable_instruction(st[2]), .wakeup_clock(wk),
        .config_load(st[3]), .config_source_wakeup(src),
        .config_divide_short(shrt), .watchdog_reload_value(rel),
        .window_boundary(win), .reset_request(req), .reset_cause(cause),
        .watchdog_enabled(en), .watchdog_count(cnt), .source_wakeup(src_q),
        .divide_short(div_q), .reload_setting(rel_q), .window_setting(win_q));
    initial begin
        forever #50 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic pulse(input logic [3:0] v);
        @(negedge clock);
        st = v;
        @(negedge clock);
        st = 4'h0;
    endtask
    task automatic cfg(input logic s, input logic d, input logic [15:0] r,
        input logic [15:0] w);
        src = s;
        shrt = d;
        rel = r;
        win = w;
        pulse(4'h8);
    endtask
    task automatic rst_dut;
        rst = 1'h1;
        repeat (16) @(negedge clock);
        rst = 1'h0;
    endtask
    task automatic wait_req(input int lim);
        n = 0;
        while (req !== 1'h1 && n < lim) begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        #4000000;
        bad_count++;
        results;
    end
    initial begin
        repeat (16) @(negedge clock);
        rst = 1'h0;
        chk("enabled", 16'h1, en);
        chk("count", 16'hFF00, cnt);
        chk("reload default", 16'hFF00, rel_q);
        chk("window default", 16'h0000, win_q);
        chk("source default", 16'h1, src_q);
        chk("divide default", 16'h1, div_q);
        wait_req(21000);
        chk("interval", 16'h1, n > 255 * TICK && n < 257 * TICK);
        chk("cause", 16'h1, cause);
        rst_dut;
        chk("reset request", 16'h0, req);
        chk("reset count", 16'hFF00, cnt);
        chk("reset enabled", 16'h1, en);
        cfg(1'h0, 1'h1, 16'hFFF0, 16'hFFF4);
        chk("reload held", 16'hFFF0, rel_q);
        chk("window held", 16'hFFF4, win_q);
        chk("source held", 16'h0, src_q);
        chk("divide held", 16'h1, div_q);
        pulse(4'h1);
        chk("early cause", 16'h2, cause);
        chk("early request", 16'h1, req);
        chk("early count", 16'hFF00, cnt);
        rst_dut;
        cfg(1'h0, 1'h1, 16'hFFF8, 16'h0000);
        pulse(4'h1);
        chk("reload", 16'hFFF8, cnt);
        wait_req(40);
        chk("wrap", 16'h0000, cnt);
        chk("overflow cause", 16'h1, cause);
        chk("ticks", 16'h0021, n[15:0]);
        rst_dut;
        cfg(1'h0, 1'h0, 16'h0000, 16'h0010);
        chk("divide long", 16'h0, div_q);
        pulse(4'h1);
        pulse(4'h2);
        repeat (100) @(negedge clock);
        chk("frozen", 16'h0000, cnt);
        chk("disabled", 16'h0, en);
        pulse(4'h6);
        repeat (300) @(negedge clock);
        chk("enabled", 16'h1, en);
        chk("long ticks", 16'h0012, cnt);
        pulse(4'h1);
        chk("late count", 16'h0000, cnt);
        chk("request", 16'h0, req);
        pulse(4'h2);
        chk("disabled again", 16'h0, en);
        pulse(4'h4);
        chk("enable alone", 16'h1, en);
        results;
    end
endmodule
bind wwdt_top wwdt_checker u_chk (.clock(clock), .rst(rst),
    .service_instruction(service_instruction),
    .watchdog_disable_instruction(watchdog_disable_instruction),
    .watchdog_enable_instruction(watchdog_enable_instruction),
    .reset_request(reset_request), .reset_cause(reset_cause),
    .watchdog_enabled(watchdog_enabled), .watchdog_count(watchdog_count),
    .reload_setting(reload_setting), .window_setting(window_setting));
